// ===== design/fedoc_defines.vh
// fedoc_defines.vh: register offsets, field positions, reset values and timing figures
// of the flash ecc / debug option control block.
// assumes: included by its bare name from every design file of the block.
`ifndef FEDOC_DEFINES_VH
`define FEDOC_DEFINES_VH

// apb address width and byte offsets of the registers
`define FEDOC_ADDR_W         12
`define FEDOC_OFS_CAP_LO     12'h000
`define FEDOC_OFS_CAP_HI     12'h004
`define FEDOC_OFS_KEEP_BASE  12'h010
`define FEDOC_OFS_KEEP_END   12'h024
`define FEDOC_OFS_KEEP_CTRL  12'h028
`define FEDOC_OFS_SEQ_CTRL   12'h030
`define FEDOC_OFS_ECC_WDATA  12'h034
`define FEDOC_OFS_OP_CMD     12'h038
`define FEDOC_OFS_OP_ADDR    12'h03C
`define FEDOC_OFS_OP_STAT    12'h040
`define FEDOC_OFS_OPT_STAT   12'h044
// option byte: printed offset kept as index, byte address is four times it
`define FEDOC_IDX_OPT_BYTE   12'h0C3
`define FEDOC_OFS_OPT_RAW    (`FEDOC_IDX_OPT_BYTE << 2)

// capture high register layout
`define FEDOC_HI_SYN_LSB     0
`define FEDOC_HI_ADR_LSB     8
// capture / keep word: address bits [19:2] above a 6-bit syndrome
`define FEDOC_SYN_W          6
`define FEDOC_LOC_W          18
`define FEDOC_KEEP_W         24
`define FEDOC_KEEP_N         3

// sequencer control and ecc write data
`define FEDOC_SEQ_STOP_BIT   0
`define FEDOC_CF_ECC_W       6
`define FEDOC_DF_ECC_W       4

// operation command fields
`define FEDOC_CMD_START_BIT  0
`define FEDOC_CMD_ERASE_BIT  1
`define FEDOC_CMD_DATA_BIT   2
// operation status fields
`define FEDOC_ST_BUSY_BIT    0
`define FEDOC_ST_DONE_BIT    1
`define FEDOC_ST_TOUT_BIT    2

// option byte fields
`define FEDOC_OPT_DBG_BIT    7
`define FEDOC_OPT_PROG_BIT   5
`define FEDOC_OPT_HOT_BIT    1
`define FEDOC_OPT_KEEP_BIT   0
`define FEDOC_OPT_FIX_MASK   8'h5C
`define FEDOC_OPT_FIX_VAL    8'h04
`define FEDOC_OPT_RESET      8'h00

// operation units: low address bits cleared per unit
`define FEDOC_CF_PROG_LSB    2
`define FEDOC_DF_PROG_LSB    0
`define FEDOC_ERASE_LSB      10

// clock rate and longest operation times
`define FEDOC_CLK_MHZ        10
`define FEDOC_CF_PROG_MAX_US 500
`define FEDOC_CF_ERASE_MAX_MS 220
`define FEDOC_DF_PROG_MAX_US 380
`define FEDOC_DF_ERASE_MAX_MS 235
`define FEDOC_TMR_W          22

`endif

// ===== design/fedoc_keep_mem.v
// fedoc_keep_mem.v: storage of the permanent ecc error capture words.
// assumes: one clock, synchronous active-low reset on the read register only;
// a word is only meaningful once the owner has marked it valid.
`timescale 1ns/1ns
`include "fedoc_defines.vh"

module fedoc_keep_mem #(
	parameter W  = `FEDOC_KEEP_W,
	parameter D  = `FEDOC_KEEP_N,
	parameter AW = 2
) (
	input  wire          clk,
	input  wire          rstn,
	input  wire          we,
	input  wire [AW-1:0] waddr,
	input  wire [W-1:0]  wdata,
	input  wire [AW-1:0] raddr,
	output reg  [W-1:0]  rdata
);

	reg [W-1:0] mem [0:D-1];

	// write port, no reset: contents are masked by the valid bits outside
	always @(posedge clk) begin
		if (we)
			mem[waddr] <= wdata;
	end

	// registered read; an address past the depth reads zero
	always @(posedge clk) begin
		if (!rstn)
			rdata <= {W{1'b0}};
		else if (raddr < D)
			rdata <= mem[raddr];
		else
			rdata <= {W{1'b0}};
	end

endmodule

// ===== design/fedoc_top.v
// fedoc_top.v: flash ecc capture, ecc sequencer stop / write data path, flash
// operation timer and debug option byte decode, with an apb register slave.
// assumes: flash macro and option loader run on CLK; option byte arrives with a
// one-cycle load strobe; software keeps out of halt/stop while FLASH_BUSY is high.
`timescale 1ns/1ns
`include "fedoc_defines.vh"

// Summary of operation
// RQ1: temporary buffer splits address, holds 6-bit syndrome
// RQ2: three permanent buffers, same split, own syndrome
// RQ3: option byte fields: debug, prog, hotplug, keep
// RQ4: prog enable low blocks programming and debugging
// RQ5: 1100 debug on, no hotplug, erase on fail
// RQ6: 1101 debug on, no hotplug, keep flash
// RQ7: 1111 debug and hotplug on, keep flash
// RQ8: stop bit zero runs ecc sequencer, one halts
// RQ9: stop zero supplies generated ecc, one software ecc
// RQ10: code flash uses 6 bits, data flash 4
// RQ11: no halt/stop during data flash rewrite
// RQ12: no halt/stop during code self-programming
// RQ13: code flash 4-byte program, 1 KB erase, limits
// RQ14: data flash 1-byte program, 1 KB erase, limits
// RQ15: programmer writes only listed option combinations
// RQ16: every bit error updates the temporary buffer
module fedoc_top #(
	parameter [`FEDOC_TMR_W-1:0] CF_PROG_CYC  = `FEDOC_CF_PROG_MAX_US * `FEDOC_CLK_MHZ,
	parameter [`FEDOC_TMR_W-1:0] CF_ERASE_CYC = `FEDOC_CF_ERASE_MAX_MS * 1000 * `FEDOC_CLK_MHZ,
	parameter [`FEDOC_TMR_W-1:0] DF_PROG_CYC  = `FEDOC_DF_PROG_MAX_US * `FEDOC_CLK_MHZ,
	parameter [`FEDOC_TMR_W-1:0] DF_ERASE_CYC = `FEDOC_DF_ERASE_MAX_MS * 1000 * `FEDOC_CLK_MHZ
) (
	input  wire                     CLK,
	input  wire                     RSTN,
	input  wire                     PSEL,
	input  wire                     PENABLE,
	input  wire                     PWRITE,
	input  wire [`FEDOC_ADDR_W-1:0] PADDR,
	input  wire [31:0]              PWDATA,
	output reg  [31:0]              PRDATA,
	output wire                     PREADY,
	output wire                     PSLVERR,
	input  wire                     ECC_ERR,
	input  wire [19:0]              ECC_ERR_ADDR,
	input  wire [5:0]               ECC_ERR_SYN,
	input  wire [5:0]               ECC_GEN,
	output reg  [5:0]               FLASH_ECC_WDATA,
	output wire                     ECC_SEQ_RUN,
	output reg                      FLASH_START,
	output reg                      FLASH_ABORT,
	output reg                      FLASH_ERASE,
	output reg                      FLASH_DATA_AREA,
	output reg  [19:0]              FLASH_ADDR,
	input  wire                     FLASH_DONE,
	output wire                     FLASH_BUSY,
	input  wire                     OPT_LOAD,
	input  wire [7:0]               OPT_BYTE,
	output wire                     SERIAL_PROG_EN,
	output wire                     DEBUG_EN,
	output wire                     HOT_PLUG_EN,
	output wire                     ERASE_ON_AUTH_FAIL,
	output wire                     OPT_ILLEGAL
);

	localparam [2:0] ST_IDLE  = 3'b001;
	localparam [2:0] ST_RUN   = 3'b010;
	localparam [2:0] ST_ABORT = 3'b100;

	// keep-buffer decode: {hit, high half, slot[1:0]}
	function [3:0] keep_decode;
		input [`FEDOC_ADDR_W-1:0] a;
		reg   [`FEDOC_ADDR_W-1:0] rel;
		begin
			rel = a - `FEDOC_OFS_KEEP_BASE;
			keep_decode = {(a >= `FEDOC_OFS_KEEP_BASE) && (a <= `FEDOC_OFS_KEEP_END) && (a[1:0] == 2'b00),
				rel[2], rel[4:3]};
		end
	endfunction

	// register state
	reg  [`FEDOC_LOC_W-1:0]  cap_loc;
	reg  [`FEDOC_SYN_W-1:0]  cap_syn;
	reg  [`FEDOC_KEEP_N-1:0] keep_valid;
	reg                      seq_stop;
	reg  [5:0]               ecc_wdata;
	reg  [19:0]              op_addr;
	reg                      op_done;
	reg                      op_tout;
	reg  [7:0]               opt_byte;
	reg  [2:0]               state;
	reg  [`FEDOC_TMR_W-1:0]  timer;
	reg  [`FEDOC_TMR_W-1:0]  limit;
	reg                      rd_done;
	reg  [31:0]              next_rdata;
	reg                      mapped;
	reg  [1:0]               free_slot;
	reg                      free_any;
	wire [`FEDOC_KEEP_W-1:0] keep_rdata;
	wire [3:0]               kdec;
	wire                     wr;
	wire                     rd_first;
	wire [`FEDOC_SYN_W-1:0]  keep_syn;
	wire [`FEDOC_LOC_W-1:0]  keep_loc;
	wire                     idle;
	wire                     prog_en;
	wire                     dbg_bit;
	wire                     hot_bit;
	wire                     keep_bit;
	wire                     combo_ok;
	wire                     op_go;
	wire                     next_area;

	assign kdec     = keep_decode(PADDR);
	assign wr       = PSEL & PENABLE & PWRITE;
	assign rd_first = PSEL & PENABLE & ~PWRITE & ~rd_done;
	assign keep_syn = keep_rdata[`FEDOC_SYN_W-1:0];
	assign keep_loc = keep_rdata[`FEDOC_KEEP_W-1:`FEDOC_SYN_W];
	assign idle     = state[0];
	// a start accepted this cycle; its area already steers the ecc width below
	assign op_go     = wr & idle & (PADDR == `FEDOC_OFS_OP_CMD) & PWDATA[`FEDOC_CMD_START_BIT];
	assign next_area = op_go ? PWDATA[`FEDOC_CMD_DATA_BIT] : FLASH_DATA_AREA;

	// writes finish in the first access cycle, reads in the second because the
	// keep words come out of a registered memory
	assign PREADY  = PSEL & PENABLE & (PWRITE | rd_done);
	assign PSLVERR = PSEL & PENABLE & ~mapped;

	// address map check
	always @* begin
		case (PADDR)
			`FEDOC_OFS_CAP_LO, `FEDOC_OFS_CAP_HI, `FEDOC_OFS_KEEP_CTRL, `FEDOC_OFS_SEQ_CTRL,
			`FEDOC_OFS_ECC_WDATA, `FEDOC_OFS_OP_CMD, `FEDOC_OFS_OP_ADDR, `FEDOC_OFS_OP_STAT,
			`FEDOC_OFS_OPT_STAT, `FEDOC_OFS_OPT_RAW: begin
				mapped = 1'b1;
			end
			default: begin
				mapped = kdec[3];
			end
		endcase
	end

	// read mux; a keep slot not yet filled reads as zero
	always @* begin
		next_rdata = 32'h0000_0000;
		if (kdec[3]) begin
			if (keep_valid[kdec[1:0]] && kdec[2])
				next_rdata = {20'h00000, keep_loc[17:14], 2'b00, keep_syn}; // [RQ2]
			else if (keep_valid[kdec[1:0]])
				next_rdata = {16'h0000, keep_loc[13:0], 2'b00}; // [RQ2]
		end else begin
			case (PADDR)
				`FEDOC_OFS_CAP_LO:    next_rdata = {16'h0000, cap_loc[13:0], 2'b00}; // [RQ1]
				`FEDOC_OFS_CAP_HI:    next_rdata = {20'h00000, cap_loc[17:14], 2'b00, cap_syn}; // [RQ1]
				`FEDOC_OFS_KEEP_CTRL: next_rdata = {29'h0000_0000, keep_valid};
				`FEDOC_OFS_SEQ_CTRL:  next_rdata = {31'h0000_0000, seq_stop};
				`FEDOC_OFS_ECC_WDATA: next_rdata = {26'h000_0000, ecc_wdata};
				`FEDOC_OFS_OP_CMD:    next_rdata = {29'h0000_0000, FLASH_DATA_AREA, FLASH_ERASE, 1'b0};
				`FEDOC_OFS_OP_ADDR:   next_rdata = {12'h000, op_addr};
				`FEDOC_OFS_OP_STAT:   next_rdata = {29'h0000_0000, op_tout, op_done, ~idle};
				`FEDOC_OFS_OPT_STAT:  next_rdata = {27'h000_0000, OPT_ILLEGAL, ERASE_ON_AUTH_FAIL,
					HOT_PLUG_EN, DEBUG_EN, SERIAL_PROG_EN};
				`FEDOC_OFS_OPT_RAW:   next_rdata = {24'h00_0000, opt_byte}; // [RQ3]
				default:              next_rdata = 32'h0000_0000;
			endcase
		end
	end

	// read data register and second-cycle flag
	always @(posedge CLK) begin
		if (!RSTN) begin
			PRDATA  <= 32'h0000_0000;
			rd_done <= 1'b0;
		end else begin
			if (rd_first)
				PRDATA <= next_rdata;
			if (PREADY)
				rd_done <= 1'b0;
			else if (rd_first)
				rd_done <= 1'b1;
		end
	end

	// lowest free permanent slot; once all three hold errors, later ones only
	// reach the temporary buffer until software frees a slot
	always @* begin
		free_any  = 1'b1;
		free_slot = 2'd0;
		if (!keep_valid[0])
			free_slot = 2'd0;
		else if (!keep_valid[1])
			free_slot = 2'd1;
		else if (!keep_valid[2])
			free_slot = 2'd2;
		else
			free_any = 1'b0;
	end

	fedoc_keep_mem #(
		.W  (`FEDOC_KEEP_W),
		.D  (`FEDOC_KEEP_N),
		.AW (2)
	) u_keep (
		.clk   (CLK),
		.rstn  (RSTN),
		.we    (ECC_ERR & free_any), // [RQ2]
		.waddr (free_slot),
		.wdata ({ECC_ERR_ADDR[19:2], ECC_ERR_SYN}),
		.raddr (kdec[1:0]),
		.rdata (keep_rdata)
	);

	// error capture; a new error in the cycle software frees a slot keeps its bit
	always @(posedge CLK) begin
		if (!RSTN) begin
			cap_loc    <= {`FEDOC_LOC_W{1'b0}};
			cap_syn    <= {`FEDOC_SYN_W{1'b0}};
			keep_valid <= {`FEDOC_KEEP_N{1'b0}};
		end else begin
			if (ECC_ERR) begin
				cap_loc <= ECC_ERR_ADDR[19:2]; // [RQ16] [RQ1]
				cap_syn <= ECC_ERR_SYN; // [RQ1]
			end
			if (wr && PADDR == `FEDOC_OFS_KEEP_CTRL)
				keep_valid <= keep_valid & ~PWDATA[`FEDOC_KEEP_N-1:0];
			if (ECC_ERR && free_any)
				keep_valid[free_slot] <= 1'b1; // [RQ2]
		end
	end

	// sequencer stop bit and ecc write data register
	always @(posedge CLK) begin
		if (!RSTN) begin
			seq_stop  <= 1'b0;
			ecc_wdata <= 6'h00;
		end else begin
			if (wr && PADDR == `FEDOC_OFS_SEQ_CTRL)
				seq_stop <= PWDATA[`FEDOC_SEQ_STOP_BIT]; // [RQ8]
			if (!seq_stop)
				ecc_wdata <= ECC_GEN; // [RQ9]
			else if (wr && PADDR == `FEDOC_OFS_ECC_WDATA)
				ecc_wdata <= PWDATA[5:0]; // [RQ9]
		end
	end

	assign ECC_SEQ_RUN = ~seq_stop; // [RQ8]

	// ecc bits to the flash, width by the area being started or run: no stale width at start
	always @(posedge CLK) begin
		if (!RSTN)
			FLASH_ECC_WDATA <= 6'h00;
		else if (next_area)
			FLASH_ECC_WDATA <= {2'b00, ecc_wdata[`FEDOC_DF_ECC_W-1:0]}; // [RQ10]
		else
			FLASH_ECC_WDATA <= ecc_wdata[`FEDOC_CF_ECC_W-1:0]; // [RQ10]
	end

	// longest time for the requested operation
	always @* begin
		case ({PWDATA[`FEDOC_CMD_DATA_BIT], PWDATA[`FEDOC_CMD_ERASE_BIT]})
			2'b00: begin
				limit = CF_PROG_CYC; // [RQ13]
			end
			2'b01: begin
				limit = CF_ERASE_CYC; // [RQ13]
			end
			2'b10: begin
				limit = DF_PROG_CYC; // [RQ14]
			end
			default: begin
				limit = DF_ERASE_CYC; // [RQ14]
			end
		endcase
	end

	// operation sequencer: a start while busy is ignored; an operation that
	// overruns its longest time is aborted rather than left hanging
	always @(posedge CLK) begin
		if (!RSTN) begin
			state           <= ST_IDLE;
			timer           <= {`FEDOC_TMR_W{1'b0}};
			op_addr         <= 20'h00000;
			op_done         <= 1'b0;
			op_tout         <= 1'b0;
			FLASH_START     <= 1'b0;
			FLASH_ABORT     <= 1'b0;
			FLASH_ERASE     <= 1'b0;
			FLASH_DATA_AREA <= 1'b0;
			FLASH_ADDR      <= 20'h00000;
		end else begin
			FLASH_START <= 1'b0;
			FLASH_ABORT <= 1'b0;
			if (wr && PADDR == `FEDOC_OFS_OP_ADDR && idle)
				op_addr <= PWDATA[19:0];
			if (wr && PADDR == `FEDOC_OFS_OP_STAT) begin
				if (PWDATA[`FEDOC_ST_DONE_BIT])
					op_done <= 1'b0;
				if (PWDATA[`FEDOC_ST_TOUT_BIT])
					op_tout <= 1'b0;
			end
			case (state)
				ST_IDLE: begin
					if (op_go) begin
						state           <= ST_RUN;
						timer           <= limit;
						FLASH_START     <= 1'b1;
						FLASH_ERASE     <= PWDATA[`FEDOC_CMD_ERASE_BIT];
						FLASH_DATA_AREA <= PWDATA[`FEDOC_CMD_DATA_BIT];
						if (PWDATA[`FEDOC_CMD_ERASE_BIT])
							FLASH_ADDR <= {op_addr[19:`FEDOC_ERASE_LSB], 10'h000}; // [RQ13] [RQ14]
						else if (PWDATA[`FEDOC_CMD_DATA_BIT])
							FLASH_ADDR <= op_addr; // [RQ14]
						else
							FLASH_ADDR <= {op_addr[19:`FEDOC_CF_PROG_LSB], 2'b00}; // [RQ13]
					end
				end
				ST_RUN: begin
					if (FLASH_DONE) begin
						state   <= ST_IDLE;
						op_done <= 1'b1;
					end else if (timer == {`FEDOC_TMR_W{1'b0}}) begin
						state       <= ST_ABORT;
						FLASH_ABORT <= 1'b1; // [RQ13] [RQ14]
						op_tout     <= 1'b1;
					end else begin
						timer <= timer - {{(`FEDOC_TMR_W-1){1'b0}}, 1'b1};
					end
				end
				ST_ABORT: begin
					state <= ST_IDLE;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// software must not enter halt/stop while this is high
	assign FLASH_BUSY = ~idle; // [RQ11] [RQ12]

	// option byte capture; until first load everything stays blocked
	always @(posedge CLK) begin
		if (!RSTN)
			opt_byte <= `FEDOC_OPT_RESET;
		else if (OPT_LOAD)
			opt_byte <= OPT_BYTE; // [RQ3]
	end

	assign prog_en  = opt_byte[`FEDOC_OPT_PROG_BIT]; // [RQ3]
	assign dbg_bit  = opt_byte[`FEDOC_OPT_DBG_BIT];
	assign hot_bit  = opt_byte[`FEDOC_OPT_HOT_BIT];
	assign keep_bit = opt_byte[`FEDOC_OPT_KEEP_BIT];
	// listed combinations only; anything else keeps debug shut as the safe side
	assign combo_ok = ({dbg_bit, hot_bit, keep_bit} == 3'b000) | ({dbg_bit, hot_bit, keep_bit} == 3'b100) |
		({dbg_bit, hot_bit, keep_bit} == 3'b101) | ({dbg_bit, hot_bit, keep_bit} == 3'b111); // [RQ15]

	// decoded gates toward the programmer / debugger
	assign SERIAL_PROG_EN     = prog_en; // [RQ4]
	assign DEBUG_EN           = prog_en & dbg_bit & combo_ok; // [RQ4] [RQ5] [RQ6] [RQ7]
	assign HOT_PLUG_EN        = prog_en & dbg_bit & hot_bit & keep_bit; // [RQ7] [RQ5] [RQ6]
	assign ERASE_ON_AUTH_FAIL = prog_en & dbg_bit & ~hot_bit & ~keep_bit; // [RQ5] [RQ6] [RQ7]
	assign OPT_ILLEGAL        = (prog_en & ~combo_ok) |
		((opt_byte & `FEDOC_OPT_FIX_MASK) != `FEDOC_OPT_FIX_VAL); // [RQ3]

endmodule

// ===== test/fedoc_properties.sv
// fedoc_properties.sv: port-level checks of the flash ecc / option control block.
// assumes: bound into fedoc_top, one clock CLK, synchronous active-low RSTN.
`timescale 1ns/1ns
`include "fedoc_defines.vh"
module fedoc_properties #(
	parameter [`FEDOC_TMR_W-1:0] CF_PROG_CYC  = 22'h14,
	parameter [`FEDOC_TMR_W-1:0] CF_ERASE_CYC = 22'h14,
	parameter [`FEDOC_TMR_W-1:0] DF_PROG_CYC  = 22'h14,
	parameter [`FEDOC_TMR_W-1:0] DF_ERASE_CYC = 22'h14
) (
	input wire                     CLK,
	input wire                     RSTN,
	input wire                     PSEL,
	input wire                     PENABLE,
	input wire                     PWRITE,
	input wire [`FEDOC_ADDR_W-1:0] PADDR,
	input wire [31:0]              PWDATA,
	input wire [5:0]               ECC_GEN,
	input wire [5:0]               FLASH_ECC_WDATA,
	input wire                     ECC_SEQ_RUN,
	input wire                     FLASH_START,
	input wire                     FLASH_ABORT,
	input wire                     FLASH_ERASE,
	input wire                     FLASH_DATA_AREA,
	input wire [19:0]              FLASH_ADDR,
	input wire                     FLASH_BUSY,
	input wire                     OPT_LOAD,
	input wire [7:0]               OPT_BYTE,
	input wire                     SERIAL_PROG_EN,
	input wire                     DEBUG_EN,
	input wire                     HOT_PLUG_EN,
	input wire                     ERASE_ON_AUTH_FAIL
);
	reg [23:0] busy_cnt;
	reg [23:0] lim;
	reg [7:0]  ob_q;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);
	// busy length, the limit of the running operation and the loaded option byte
	always @(posedge CLK) begin
		busy_cnt <= (!RSTN || !FLASH_BUSY) ? 24'h0 : busy_cnt + 24'h1;
		ob_q <= !RSTN ? 8'h00 : (OPT_LOAD ? OPT_BYTE : ob_q);
		if (!RSTN)
			lim <= 24'h0;
		else if (FLASH_START)
			lim <= {2'b00, FLASH_ERASE ? (FLASH_DATA_AREA ? DF_ERASE_CYC : CF_ERASE_CYC)
				: (FLASH_DATA_AREA ? DF_PROG_CYC : CF_PROG_CYC)};
	end
	a_seq_stop: assert property (PSEL && PENABLE && PWRITE && PADDR == `FEDOC_OFS_SEQ_CTRL
		|=> ECC_SEQ_RUN == !$past(PWDATA[0])) else $error("sequencer run does not follow stop bit");
	a_opt_prog: assert property (SERIAL_PROG_EN == ob_q[5])
		else $error("programming enable wrong");
	a_erase_fail: assert property (ERASE_ON_AUTH_FAIL == (ob_q[7] && ob_q[5] && !ob_q[1] && !ob_q[0]))
		else $error("erase on failure wrong");
	a_debug_en: assert property (DEBUG_EN == (ob_q[7] && ob_q[5] && (!ob_q[1] || ob_q[0])))
		else $error("debug enable wrong");
	a_hot_plug: assert property (HOT_PLUG_EN == (ob_q[7] && ob_q[5] && ob_q[1] && ob_q[0]))
		else $error("hot plug enable wrong");
	a_gen_follow: assert property ((ECC_SEQ_RUN && !FLASH_DATA_AREA && $stable(ECC_GEN)) [*3]
		|-> FLASH_ECC_WDATA == ECC_GEN) else $error("generated ecc not passed on");
	a_data_mask: assert property (FLASH_DATA_AREA |-> FLASH_ECC_WDATA[5:4] == 2'b00)
		else $error("data flash ecc wider than four bits");
	a_erase_block: assert property (FLASH_START && FLASH_ERASE |-> FLASH_ADDR[9:0] == 10'h000)
		else $error("erase address not block aligned");
	a_prog_word: assert property (FLASH_START && !FLASH_ERASE && !FLASH_DATA_AREA
		|-> FLASH_ADDR[1:0] == 2'b00) else $error("code program address not word aligned");
	a_op_limit: assert property (FLASH_BUSY && !FLASH_START |-> busy_cnt <= lim + 24'h1)
		else $error("operation outlived its limit");
	a_abort_late: assert property (FLASH_ABORT |-> busy_cnt == lim + 24'h1)
		else $error("operation aborted too early");
endmodule
bind fedoc_top fedoc_properties #(.CF_PROG_CYC(CF_PROG_CYC), .CF_ERASE_CYC(CF_ERASE_CYC),
	.DF_PROG_CYC(DF_PROG_CYC), .DF_ERASE_CYC(DF_ERASE_CYC)) u_props (.*);

// ===== test/fedoc_flash_model.sv
// fedoc_flash_model.sv: behavioural flash macro on the far side of the operation port.
// assumes: start and abort are one-cycle pulses from fedoc_top on the same clock.
`timescale 1ns/1ns
module fedoc_flash_model (
	input wire       clk,
	input wire       rstn,
	input wire       start,
	input wire       abort,
	input wire [7:0] delay,
	output reg       done
);
	reg       run;
	reg [7:0] left;
	// finish after the requested delay; an abort drops the operation with no answer
	always @(posedge clk) begin
		done <= 1'b0;
		if (!rstn || abort) begin
			run <= 1'b0;
		end else if (start) begin
			run <= 1'b1;
			left <= delay;
		end else if (run && left == 8'h00) begin
			done <= 1'b1;
			run <= 1'b0;
		end else if (run) begin
			left <= left - 8'h01;
		end
	end
endmodule

// ===== test/fedoc_top_test.sv
// fedoc_top_test.sv: self-checking bench of the flash ecc / option control block.
// assumes: fedoc_top, fedoc_flash_model and the bound checker compile alongside.
`timescale 1ns/1ns
`include "fedoc_defines.vh"
module fedoc_top_test;
	// option rows, expected status per row, ops as {2'b0, delay, erase, data, address}
	localparam [55:0]  OBS = 56'h0484A4A5A724AC;
	localparam [55:0]  OST = 56'h00000B0307011B;
	localparam [159:0] OPS = 160'h00C12347_01500333_02A12FFF_3230ABCD_32000006;
	reg         clk = 1'b0;
	reg         rstn = 1'b0;
	reg         psel = 1'b0;
	reg         penable = 1'b0;
	reg         pwrite = 1'b0;
	reg         ecc_err = 1'b0;
	reg         opt_load = 1'b0;
	reg  [11:0] paddr = 12'h000;
	reg  [31:0] pwdata = 32'h0;
	reg  [19:0] ecc_err_addr = 20'h0;
	reg  [5:0]  ecc_err_syn = 6'h0;
	reg  [5:0]  ecc_gen = 6'h15;
	reg  [7:0]  opt_byte = 8'h0;
	reg  [7:0]  flash_delay = 8'h0;
	wire [31:0] prdata;
	wire [5:0]  flash_ecc_wdata;
	wire [19:0] flash_addr;
	wire        pready, pslverr, ecc_seq_run, flash_start, flash_abort, flash_erase, flash_data_area;
	wire        flash_done, flash_busy, serial_prog_en, debug_en, hot_plug_en, erase_on_auth_fail, opt_illegal;
	integer     n_errors = 0;
	integer     n_checks = 0;
	integer     cyc = 0;
	integer     i;
	reg         last_err;
	reg  [31:0] rd;
	reg  [31:0] w;
	reg  [19:0] ea;
	reg  [5:0]  es;
	reg  [11:0] k;
	reg  [19:0] ka [0:2];
	reg  [5:0]  ks [0:2];
	// short limits keep the abort cases quick
	fedoc_top #(.CF_PROG_CYC(22'h14), .CF_ERASE_CYC(22'h28), .DF_PROG_CYC(22'h18), .DF_ERASE_CYC(22'h30)) u_dut (
		.CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .ECC_ERR(ecc_err),
		.ECC_ERR_ADDR(ecc_err_addr), .ECC_ERR_SYN(ecc_err_syn), .ECC_GEN(ecc_gen),
		.FLASH_ECC_WDATA(flash_ecc_wdata), .ECC_SEQ_RUN(ecc_seq_run), .FLASH_START(flash_start),
		.FLASH_ABORT(flash_abort), .FLASH_ERASE(flash_erase), .FLASH_DATA_AREA(flash_data_area),
		.FLASH_ADDR(flash_addr), .FLASH_DONE(flash_done), .FLASH_BUSY(flash_busy), .OPT_LOAD(opt_load),
		.OPT_BYTE(opt_byte), .SERIAL_PROG_EN(serial_prog_en), .DEBUG_EN(debug_en), .HOT_PLUG_EN(hot_plug_en),
		.ERASE_ON_AUTH_FAIL(erase_on_auth_fail), .OPT_ILLEGAL(opt_illegal));
	fedoc_flash_model u_flash (.clk(clk), .rstn(rstn), .start(flash_start), .abort(flash_abort),
		.delay(flash_delay), .done(flash_done));
	// clock and hang guard
	always #50 clk = ~clk;
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc > 5000) begin
			n_errors = n_errors + 1;
			$display("Error timeout expected 0 seen %0d", cyc);
			finish_test;
		end
	end
	task chk(input [8*10:1] name, input [31:0] exp, input [31:0] got);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("Error %0s expected %h seen %h", name, exp, got);
			end
		end
	endtask
	// one apb transfer; request held until pready is sampled high
	task apb(input wr, input [11:0] a, input [31:0] d);
		begin
			@(posedge clk);
			psel <= 1'b1;
			penable <= 1'b0;
			pwrite <= wr;
			paddr <= a;
			pwdata <= d;
			@(posedge clk);
			penable <= 1'b1;
			do @(posedge clk); while (pready !== 1'b1);
			rd = prdata;
			last_err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task finish_test;
		begin
			$display("checks %0d errors %0d", n_checks, n_errors);
			if (n_errors == 0 && n_checks > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		apb(1'b0, `FEDOC_OFS_OPT_STAT, 32'h0);
		chk("opt_stat", 32'h10, rd);
		chk("seq_run", 32'h1, {31'h0, ecc_seq_run});
		apb(1'b0, 12'h0FC, 32'h0);
		chk("unmapped", 32'h1, {31'h0, last_err});
		// four errors: three fill the kept slots, the fourth lands only in the temporary one
		for (i = 0; i < 4; i = i + 1) begin
			w = 32'h1A5C7 + i * 32'h2D0B1;
			ea = w[19:0];
			es = 6'h21 + 6'h07 * i[5:0];
			@(posedge clk);
			ecc_err <= 1'b1;
			ecc_err_addr <= ea;
			ecc_err_syn <= es;
			@(posedge clk);
			ecc_err <= 1'b0;
			if (i < 3) begin
				ka[i] = ea;
				ks[i] = es;
			end
			apb(1'b0, `FEDOC_OFS_CAP_LO, 32'h0);
			chk("cap_lo", {16'h0, ea[15:2], 2'b00}, rd);
			apb(1'b0, `FEDOC_OFS_CAP_HI, 32'h0);
			chk("cap_hi", {20'h0, ea[19:16], 2'b00, es}, rd);
		end
		for (i = 0; i < 3; i = i + 1) begin
			k = `FEDOC_OFS_KEEP_BASE + {i[8:0], 3'b000};
			apb(1'b0, k, 32'h0);
			chk("keep_lo", {16'h0, ka[i][15:2], 2'b00}, rd);
			apb(1'b0, k + 12'h004, 32'h0);
			chk("keep_hi", {20'h0, ka[i][19:16], 2'b00, ks[i]}, rd);
		end
		apb(1'b1, `FEDOC_OFS_KEEP_CTRL, 32'h2);
		apb(1'b0, `FEDOC_OFS_KEEP_CTRL, 32'h0);
		chk("keep_vld", 32'h5, rd);
		// option byte rows: listed control combinations only, the last with a bad fixed bit
		for (i = 0; i < 7; i = i + 1) begin
			@(posedge clk);
			opt_load <= 1'b1;
			opt_byte <= OBS[8*(6-i)+:8];
			@(posedge clk);
			opt_load <= 1'b0;
			apb(1'b0, `FEDOC_OFS_OPT_STAT, 32'h0);
			chk("opt_stat", {24'h0, OST[8*(6-i)+:8]}, rd);
			chk("opt_pins", {27'h0, OST[8*(6-i)+:5]}, {27'h0, opt_illegal, erase_on_auth_fail,
				hot_plug_en, debug_en, serial_prog_en});
			apb(1'b0, `FEDOC_IDX_OPT_BYTE << 2, 32'h0);
			chk("opt_raw", {24'h0, OBS[8*(6-i)+:8]}, rd);
		end
		// running sequencer ignores software ecc; stopped, software ecc sticks
		apb(1'b1, `FEDOC_OFS_ECC_WDATA, 32'h2A);
		apb(1'b0, `FEDOC_OFS_ECC_WDATA, 32'h0);
		chk("ecc_wdata", 32'h15, rd);
		apb(1'b1, `FEDOC_OFS_SEQ_CTRL, 32'h1);
		apb(1'b1, `FEDOC_OFS_ECC_WDATA, 32'h3F);
		ecc_gen <= 6'h0A;
		apb(1'b0, `FEDOC_OFS_ECC_WDATA, 32'h0);
		chk("ecc_wdata", 32'h3F, rd);
		chk("seq_run", 32'h0, {31'h0, ecc_seq_run});
		// flash operations: prompt ones finish, slow ones are aborted
		for (i = 0; i < 5; i = i + 1) begin
			w = OPS[32*(4-i)+:32];
			flash_delay <= w[29:22];
			apb(1'b1, `FEDOC_OFS_OP_ADDR, {12'h0, w[19:0]});
			apb(1'b1, `FEDOC_OFS_OP_CMD, {29'h0, w[20], w[21], 1'b1});
			ea = w[21] ? {w[19:10], 10'h0} : (w[20] ? w[19:0] : {w[19:2], 2'b00});
			repeat (2) @(negedge clk);
			chk("op_addr", {12'h0, ea}, {12'h0, flash_addr});
			chk("op_kind", {30'h0, w[21:20]}, {30'h0, flash_erase, flash_data_area});
			chk("ecc_out", w[20] ? 32'h0F : 32'h3F, {26'h0, flash_ecc_wdata});
			// software stays out of standby until the operation ends
			while (flash_busy !== 1'b0) @(negedge clk);
			apb(1'b0, `FEDOC_OFS_OP_STAT, 32'h0);
			chk("op_stat", w[29] ? 32'h4 : 32'h2, rd);
			apb(1'b1, `FEDOC_OFS_OP_STAT, 32'h6);
		end
		apb(1'b1, `FEDOC_OFS_SEQ_CTRL, 32'h0);
		repeat (3) @(posedge clk);
		apb(1'b0, `FEDOC_OFS_ECC_WDATA, 32'h0);
		chk("ecc_wdata", 32'h0A, rd);
		chk("seq_run", 32'h1, {31'h0, ecc_seq_run});
		finish_test;
	end
endmodule
